/* logic/sitc_pkg.sv */
/*
  Package for the system-instruction decode and execute block:
  encodings, field positions, reset values and the bus map.
  Assumes a 32-bit core with R-type instruction words.
*/
package sitc_pkg;
  // ----------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------
  localparam logic [5:0]  OP_RTYPE      = 6'h3A;
  localparam logic [5:0]  OPX_BARRIER   = 6'h36;
  localparam logic [5:0]  OPX_SWEXC     = 6'h2D;
  localparam logic [5:0]  OPX_CTLWR     = 6'h2E;
  localparam logic [4:0]  SWEXC_C       = 5'h1C;
  localparam int          OP_LSB        = 0;
  localparam int          OPX_LSB       = 11;
  localparam int          IDX_LSB       = 6;
  localparam int          C_LSB         = 17;
  localparam int          A_LSB         = 27;
  localparam logic [31:0] PC_STEP       = 32'h0000_0004;
  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int          ST_IRQ_EN     = 0;
  localparam int          ST_USER       = 1;
  localparam logic [31:0] STATUS_RST    = 32'h0000_0000;
  localparam logic [31:0] HANDLER_DEF   = 32'h0000_0020;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  A_STATUS      = 8'h00;
  localparam logic [7:0]  A_SAVED       = 8'h04;
  localparam logic [7:0]  A_RETADDR     = 8'h08;
  localparam logic [7:0]  A_IRQ_STAT    = 8'h0C;
  localparam logic [7:0]  A_IRQ_MASK    = 8'h10;
  localparam logic [7:0]  A_CONFIG      = 8'h14;
  localparam logic [7:0]  A_TAG         = 8'h18;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  // Event bits: 0 barrier done, 1 trap, 2 privilege fault, 3 ctl write
  localparam int          N_EVT         = 4;

  // Decoded instruction
  typedef struct packed {
    logic [4:0] a_idx;
    logic [4:0] b_idx;
    logic [4:0] c_fld;
    logic [5:0] opx;
    logic [4:0] idx;
    logic [5:0] op;
  } sitc_instr_t;

  // Control register write toward the core
  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [31:0] data;
  } sitc_ctlwr_t;
endpackage : sitc_pkg

/* logic/sitc_core.sv */
/*
  Decode and execute of barrier, software exception and control write.
  Assumes: instructions arrive with issue_valid for one cycle while
  stall is low; the register file value of operand A comes with it;
  mem_outstanding reports pending data accesses; AXI4-Lite slave.
*/
`timescale 1ns/1ps
module sitc_core #(
  parameter bit          IN_ORDER_ONLY = 1'b0,
  parameter logic [31:0] HANDLER_ADDR  = sitc_pkg::HANDLER_DEF
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Instruction issue
  input  wire logic              issue_valid,
  input  wire logic [31:0]       issue_instr,
  input  wire logic [31:0]       issue_pc,
  input  wire logic [31:0]       operand_a,
  input  wire logic              mem_outstanding,
  input  wire logic              eret_valid,
  output logic                   stall,
  // Program counter redirect
  output logic                   pc_load,
  output logic [31:0]            pc_target,
  output logic                   priv_fault,
  output logic [4:0]             exception_tag_field,
  output sitc_pkg::sitc_ctlwr_t  ctl_wr,
  output logic [31:0]            status_out,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [7:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Interrupt
  output logic                   irq
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  // The handler is fetched as a whole word, so its address must be aligned
  if (HANDLER_ADDR[1:0] != 2'b00) begin : g_bad_handler
    $error("sitc_core: HANDLER_ADDR must be word aligned");
  end
  // The event vector and its readback are built for exactly four bits
  if (sitc_pkg::N_EVT != 4) begin : g_bad_evt
    $error("sitc_core: event count does not match the event vector");
  end

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  sitc_pkg::sitc_instr_t ins;
  logic is_bar, is_trap, is_ctl, user_q_bit;
  logic [31:0] status_q, saved_q, retaddr_q, tag_q;
  logic [sitc_pkg::N_EVT-1:0] evt_stat_q, evt_mask_q, evt;
  logic cfg_force_nop_q, barrier_wait_q;

  // An issue offered during stall decodes to nothing, so it leaves no trace
  assign ins     = sitc_pkg::sitc_instr_t'(issue_instr);
  assign is_bar  = issue_valid && !stall && ins.op == sitc_pkg::OP_RTYPE
                   && ins.opx == sitc_pkg::OPX_BARRIER;
  assign is_trap = issue_valid && !stall && ins.op == sitc_pkg::OP_RTYPE
                   && ins.opx == sitc_pkg::OPX_SWEXC && ins.c_fld == sitc_pkg::SWEXC_C;
  assign is_ctl  = issue_valid && !stall && ins.op == sitc_pkg::OP_RTYPE
                   && ins.opx == sitc_pkg::OPX_CTLWR;
  assign user_q_bit = status_q[sitc_pkg::ST_USER];

  // ------------------------------------------------------------------
  // Barrier
  // ------------------------------------------------------------------
  // Hold issue while accesses drain; in-order cores skip the wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      barrier_wait_q <= 1'b0;
    end else if (is_bar && !IN_ORDER_ONLY && !cfg_force_nop_q) begin
      barrier_wait_q <= 1'b1;
    end else if (barrier_wait_q && !mem_outstanding) begin
      barrier_wait_q <= 1'b0;
    end
  end

  // Stall is a flop; the cycle after issue already blocks the next one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall <= 1'b0;
    end else begin
      stall <= (is_bar && !IN_ORDER_ONLY && !cfg_force_nop_q)
               || (barrier_wait_q && mem_outstanding);
    end
  end

  // ------------------------------------------------------------------
  // Status, saved status, return address
  // ------------------------------------------------------------------
  // Bus write strobe, decoded with the write path further down
  logic bus_wr;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;

  // Trap saves state; eret restores it (handler's return path)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q  <= sitc_pkg::STATUS_RST;
      saved_q   <= sitc_pkg::STATUS_RST;
      retaddr_q <= '0;
    end else if (is_trap) begin
      saved_q   <= status_q;
      status_q  <= status_q & ~((32'h1 << sitc_pkg::ST_IRQ_EN)
                                | (32'h1 << sitc_pkg::ST_USER));
      retaddr_q <= issue_pc + sitc_pkg::PC_STEP;
    end else if (eret_valid) begin
      status_q  <= saved_q;
    end else if (bus_wr && wr_addr_q == sitc_pkg::A_STATUS) begin
      status_q  <= wr_data_q;
    end
  end

  // Tag is only recorded for a debugger, never steers execution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_q               <= '0;
      exception_tag_field <= '0;
    end else if (is_trap) begin
      tag_q               <= {27'h0000000, ins.idx};
      exception_tag_field <= ins.idx;
    end
  end

  // ------------------------------------------------------------------
  // Redirect, control write, fault
  // ------------------------------------------------------------------
  // User-mode write is dropped and becomes a fault redirect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_load    <= 1'b0;
      pc_target  <= '0;
      priv_fault <= 1'b0;
      ctl_wr     <= '0;
    end else begin
      pc_load    <= is_trap || (is_ctl && user_q_bit);
      pc_target  <= HANDLER_ADDR;
      priv_fault <= is_ctl && user_q_bit;
      ctl_wr.valid <= is_ctl && !user_q_bit;
      ctl_wr.idx   <= ins.idx;
      ctl_wr.data  <= operand_a;
    end
  end

  // Registered copy keeps the port off the status logic; it lags by a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_out <= sitc_pkg::STATUS_RST;
    end else begin
      status_out <= status_q;
    end
  end

  // ------------------------------------------------------------------
  // Events and interrupt
  // ------------------------------------------------------------------
  // One pulse per event; the barrier event marks the end of the drain
  assign evt = {is_ctl && !user_q_bit, is_ctl && user_q_bit, is_trap,
                barrier_wait_q && !mem_outstanding};

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_q <= '0;
    end else if (bus_wr && wr_addr_q == sitc_pkg::A_IRQ_STAT) begin
      evt_stat_q <= (evt_stat_q & ~wr_data_q[sitc_pkg::N_EVT-1:0]) | evt;
    end else begin
      evt_stat_q <= evt_stat_q | evt;
    end
  end

  // Level interrupt while any unmasked event bit stays set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_stat_q & evt_mask_q);
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------------
  // A write commits once both halves are in and no response is pending
  logic aw_have_q, w_have_q;
  assign bus_wr = aw_have_q && w_have_q && !s_bvalid;

  // Address and data are latched independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= sitc_pkg::RESP_OKAY;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      s_awready <= !aw_have_q && !s_awready && !s_bvalid;
      s_wready  <= !w_have_q && !s_wready && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        wr_addr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_q  <= 1'b1;
        wr_data_q <= s_wdata;
      end
      if (bus_wr) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (wr_addr_q == sitc_pkg::A_STATUS || wr_addr_q == sitc_pkg::A_IRQ_STAT
                      || wr_addr_q == sitc_pkg::A_IRQ_MASK || wr_addr_q == sitc_pkg::A_CONFIG)
                     ? sitc_pkg::RESP_OKAY : sitc_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
      end
    end
  end

  // Byte strobes are ignored: registers take whole words only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_q      <= '0;
      cfg_force_nop_q <= 1'b0;
    end else if (bus_wr && wr_addr_q == sitc_pkg::A_IRQ_MASK) begin
      evt_mask_q      <= wr_data_q[sitc_pkg::N_EVT-1:0];
    end else if (bus_wr && wr_addr_q == sitc_pkg::A_CONFIG) begin
      cfg_force_nop_q <= wr_data_q[0];
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_ok;
  // Address decode; an unmapped offset answers with an error response
  always_comb begin
    rd_mux = '0;
    rd_ok  = 1'b1;
    case (s_araddr)
      sitc_pkg::A_STATUS:   rd_mux = status_q;
      sitc_pkg::A_SAVED:    rd_mux = saved_q;
      sitc_pkg::A_RETADDR:  rd_mux = retaddr_q;
      sitc_pkg::A_IRQ_STAT: rd_mux = {28'h0000000, evt_stat_q};
      sitc_pkg::A_IRQ_MASK: rd_mux = {28'h0000000, evt_mask_q};
      sitc_pkg::A_CONFIG:   rd_mux = {31'h00000000, cfg_force_nop_q};
      sitc_pkg::A_TAG:      rd_mux = tag_q;
      default:              rd_ok  = 1'b0;
    endcase
  end

  // Data is latched at the address handshake and held until it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= sitc_pkg::RESP_OKAY;
    end else begin
      s_arready <= !s_arready && !s_rvalid && s_arvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_mux;
        s_rresp  <= rd_ok ? sitc_pkg::RESP_OKAY : sitc_pkg::RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule : sitc_core

/* verification/sitc_core_props.sv */
/*
  Checker for the instruction side of sitc_core.
  Assumes it sees only the top ports; bound in below.
*/
`timescale 1ns/1ps
module sitc_core_props #(
  parameter bit          IN_ORDER_ONLY = 1'b0,
  parameter logic [31:0] HANDLER_ADDR  = sitc_pkg::HANDLER_DEF
) (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Issue side
  input wire logic                  issue_valid,
  input wire logic [31:0]           issue_instr,
  input wire logic [31:0]           operand_a,
  input wire logic                  mem_outstanding,
  // Results
  input wire logic                  stall,
  input wire logic                  pc_load,
  input wire logic [31:0]           pc_target,
  input wire logic                  priv_fault,
  input wire logic [4:0]            exception_tag_field,
  input wire sitc_pkg::sitc_ctlwr_t ctl_wr,
  input wire logic [31:0]           status_out
);
  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  logic       tk;
  logic [5:0] opx;
  // Refused issues during stall must leave no trace
  assign tk  = issue_valid && !stall && issue_instr[5:0] == sitc_pkg::OP_RTYPE;
  assign opx = issue_instr[16:11];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_trap;
    tk && opx == sitc_pkg::OPX_SWEXC && issue_instr[21:17] == sitc_pkg::SWEXC_C;
  endsequence
  // The status copy lags the live status by a cycle, so the mode is read then
  sequence s_wr(bit u);
    tk && opx == sitc_pkg::OPX_CTLWR ##1 status_out[sitc_pkg::ST_USER] == u;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_trap_vector: assert property (s_trap |=> pc_load && pc_target == HANDLER_ADDR)
    else $error("trap did not vector");
  a_trap_mode: assert property (s_trap |=> ##1 status_out[sitc_pkg::ST_IRQ_EN] == 1'b0
    && status_out[sitc_pkg::ST_USER] == 1'b0)
    else $error("trap left irq or user set");
  a_trap_tag: assert property (s_trap |=> exception_tag_field == $past(issue_instr[10:6]))
    else $error("tag not passed along");
  a_redirect_cause: assert property (pc_load && !priv_fault |-> $past(tk && opx == sitc_pkg::OPX_SWEXC
    && issue_instr[21:17] == sitc_pkg::SWEXC_C))
    else $error("redirect without trap");
  a_ctl_store: assert property (s_wr(1'b0) |-> ctl_wr.valid && ctl_wr.idx == $past(issue_instr[10:6])
    && ctl_wr.data == $past(operand_a))
    else $error("control write wrong");
  a_ctl_priv: assert property (s_wr(1'b1) |-> priv_fault && !ctl_wr.valid)
    else $error("user control write not refused");
  a_drain_hold: assert property (stall && mem_outstanding |=> stall)
    else $error("stall dropped while accesses pending");
  a_drain_release: assert property (stall && !mem_outstanding |-> ##[1:2] !stall)
    else $error("stall held after drain");
  a_stall_cause: assert property ($rose(stall) |-> !IN_ORDER_ONLY
    && $past(tk && opx == sitc_pkg::OPX_BARRIER))
    else $error("stall without barrier");
endmodule : sitc_core_props

bind sitc_core sitc_core_props #(.IN_ORDER_ONLY(IN_ORDER_ONLY), .HANDLER_ADDR(HANDLER_ADDR)) u_props (
  .aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid), .issue_instr(issue_instr),
  .operand_a(operand_a), .mem_outstanding(mem_outstanding), .stall(stall), .pc_load(pc_load),
  .pc_target(pc_target), .priv_fault(priv_fault), .exception_tag_field(exception_tag_field),
  .ctl_wr(ctl_wr), .status_out(status_out));

/* verification/sitc_mem_model.sv */
/*
  Data memory port model: keeps accesses pending for a count.
  Assumes the bench requests a burst with a one-cycle start.
*/
`timescale 1ns/1ps
module sitc_mem_model (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Burst request
  input wire logic       start,
  input wire logic [3:0] len,
  // Toward the block
  output logic           mem_outstanding
);
  logic [3:0] cnt_q;
  // One access retires per cycle; slow enough to make a barrier wait
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cnt_q <= 4'h0;
    else if (start)
      cnt_q <= len;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
  assign mem_outstanding = cnt_q != 4'h0;
endmodule : sitc_mem_model

/* verification/test_sitc_core.sv */
/*
  Testbench for sitc_core: register bus, trap, control write, barrier.
  Assumes the memory model drives mem_outstanding.
*/
`timescale 1ns/1ps
module test_sitc_core;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic aclk = 0, aresetn = 0, issue_valid = 0, eret_valid = 0, mstart = 0;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [31:0] issue_instr = 0, issue_pc = 0, operand_a = 0, s_wdata = 0, pc_target, status_out, s_rdata;
  logic [7:0] s_awaddr = 0, s_araddr = 0;
  logic [3:0] mlen = 0;
  logic stall, pc_load, priv_fault, irq, mem_outstanding, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [4:0] exception_tag_field;
  logic [1:0] s_bresp, s_rresp;
  sitc_pkg::sitc_ctlwr_t ctl_wr;
  int mismatches = 0;
  int tests_run = 0;
  always #4 aclk = ~aclk;
  sitc_core dut (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .issue_pc(issue_pc), .operand_a(operand_a), .mem_outstanding(mem_outstanding), .eret_valid(eret_valid),
    .stall(stall), .pc_load(pc_load), .pc_target(pc_target), .priv_fault(priv_fault),
    .exception_tag_field(exception_tag_field), .ctl_wr(ctl_wr), .status_out(status_out),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .irq(irq));
  sitc_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .start(mstart), .len(mlen),
    .mem_outstanding(mem_outstanding));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("Counts: %0d compared, %0d wrong", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // Bounded waits end here rather than hanging
  task automatic tmo;
    mismatches++;
    tally_and_finish();
  endtask : tmo
  function automatic logic [31:0] ins(input logic [5:0] x, input logic [4:0] c, n, a);
    return {a, 5'h00, c, x, n, sitc_pkg::OP_RTYPE};
  endfunction : ins
  // Readies are registered, so a negedge look predicts the next edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw, w, b;
    aw = 1;
    w = 1;
    b = 1;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    for (int n = 0; aw || w || b; n++) begin
      if (n == 40)
        tmo();
      @(negedge aclk);
      aw = aw && !s_awready;
      w = w && !s_wready;
      if (b && s_bvalid)
        chk(s_bresp, e);
      b = b && !s_bvalid;
      @(posedge aclk);
      s_awvalid <= aw;
      s_wvalid <= w;
      s_bready <= b;
    end
    // Registered side effects of the write are settled by this point
    @(negedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ar, r;
    ar = 1;
    r = 1;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    for (int n = 0; ar || r; n++) begin
      if (n == 40)
        tmo();
      @(negedge aclk);
      ar = ar && !s_arready;
      if (r && s_rvalid) begin
        chk(s_rresp, e);
        if (e == sitc_pkg::RESP_OKAY)
          chk(s_rdata, d);
      end
      r = r && !s_rvalid;
      @(posedge aclk);
      s_arvalid <= ar;
      s_rready <= r;
    end
  endtask : axr
  // One-cycle issue; pulses are looked at in the cycle after
  task automatic issue(input logic [31:0] i, input logic [31:0] a, input logic [31:0] pc);
    @(posedge aclk);
    issue_instr <= i;
    operand_a <= a;
    issue_pc <= pc;
    issue_valid <= 1;
    @(posedge aclk);
    issue_valid <= 0;
    @(negedge aclk);
  endtask : issue
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_trap;
    axr(sitc_pkg::A_STATUS, 32'h0, sitc_pkg::RESP_OKAY);
    axr(8'h40, 32'h0, sitc_pkg::RESP_SLVERR);
    axw(sitc_pkg::A_STATUS, 32'h3, sitc_pkg::RESP_OKAY);
    axw(sitc_pkg::A_IRQ_MASK, 32'hF, sitc_pkg::RESP_OKAY);
    issue(ins(sitc_pkg::OPX_SWEXC, sitc_pkg::SWEXC_C, 5'h00, 5'h00), 32'h0, 32'h1000);
    chk(pc_load, 1'b1);
    chk(pc_target, sitc_pkg::HANDLER_DEF);
    @(negedge aclk);
    chk(status_out, 32'h0);
    axr(sitc_pkg::A_STATUS, 32'h0, sitc_pkg::RESP_OKAY);
    axr(sitc_pkg::A_SAVED, 32'h3, sitc_pkg::RESP_OKAY);
    axr(sitc_pkg::A_RETADDR, 32'h1004, sitc_pkg::RESP_OKAY);
    chk(irq, 1'b1);
    axw(sitc_pkg::A_IRQ_MASK, 32'h0, sitc_pkg::RESP_OKAY);
    chk(irq, 1'b0);
    axw(sitc_pkg::A_IRQ_MASK, 32'hF, sitc_pkg::RESP_OKAY);
    axw(sitc_pkg::A_IRQ_STAT, 32'hF, sitc_pkg::RESP_OKAY);
    chk(irq, 1'b0);
    @(posedge aclk);
    eret_valid <= 1;
    @(posedge aclk);
    eret_valid <= 0;
    axr(sitc_pkg::A_STATUS, 32'h3, sitc_pkg::RESP_OKAY);
    issue(ins(sitc_pkg::OPX_SWEXC, sitc_pkg::SWEXC_C, 5'h15, 5'h00), 32'h0, 32'hFFFC);
    chk(exception_tag_field, 5'h15);
    chk(pc_target, sitc_pkg::HANDLER_DEF);
    axr(sitc_pkg::A_TAG, 32'h15, sitc_pkg::RESP_OKAY);
    axr(sitc_pkg::A_RETADDR, 32'h10000, sitc_pkg::RESP_OKAY);
    $display("trap test done");
  endtask : t_trap
  task automatic t_ctl;
    axw(sitc_pkg::A_STATUS, 32'h0, sitc_pkg::RESP_OKAY);
    issue(ins(sitc_pkg::OPX_CTLWR, 5'h00, 5'h06, 5'h03), 32'hA5A5_5A5A, 32'h0);
    chk({ctl_wr.valid, ctl_wr.idx}, 6'h26);
    chk(ctl_wr.data, 32'hA5A5_5A5A);
    axw(sitc_pkg::A_STATUS, 32'h2, sitc_pkg::RESP_OKAY);
    issue(ins(sitc_pkg::OPX_CTLWR, 5'h00, 5'h1F, 5'h1F), 32'hFFFF_FFFF, 32'h0);
    chk({priv_fault, ctl_wr.valid}, 2'b10);
    chk(pc_load, 1'b1);
    $display("control write test done");
  endtask : t_ctl
  task automatic t_bar(input logic cfg);
    axw(sitc_pkg::A_CONFIG, {31'h0, cfg}, sitc_pkg::RESP_OKAY);
    @(posedge aclk);
    mstart <= 1;
    mlen <= 4'hA;
    @(posedge aclk);
    mstart <= 0;
    issue(ins(sitc_pkg::OPX_BARRIER, 5'h00, 5'h00, 5'h00), 32'h0, 32'h0);
    chk(stall, !cfg);
    issue(ins(sitc_pkg::OPX_SWEXC, sitc_pkg::SWEXC_C, 5'h00, 5'h00), 32'h0, 32'h0);
    chk(pc_load, cfg);
    for (int n = 0; stall; n++) begin
      if (n == 40)
        tmo();
      @(negedge aclk);
    end
    // A waiting barrier leaves nothing pending; a no-op one leaves the burst running
    chk(mem_outstanding, cfg);
    $display("barrier test done");
  endtask : t_bar
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_trap();
    t_ctl();
    t_bar(1'b0);
    t_bar(1'b1);
    tally_and_finish();
  end
endmodule : test_sitc_core
